// file: src/sram_boundary_scan_tap.v
`timescale 1ns/10ps
`include "tap_defs.vh"

// Summary of operation
// - serial test port behaves as a standard boundary-scan access port.
// - mode select and data in are sampled on test clock rising edges.
// - test data out changes only on test clock falling edges.
// - undriven mode select reads as one.
// - undriven data in reads as one.
// - state and held instruction pick the register between data in and out.
// - data out enabled only in states that call for it.
// - no dedicated test reset pin; only mode select and power-up reset.
// - five high mode-select rising edges force test-logic-reset.
// - controller resets by itself at power-up.
// - without test clock edges the port stays inactive.
// - 3-bit instruction, preset to identification at power-up and reset state.
// - capture-instruction loads 01 into the two low instruction bits.
// - 32-bit identification register, constant capture, bit 0 shifted first.
// - bypass is a single flip-flop stage between data in and out.
module sram_boundary_scan_tap
(
	input wire sys_clk,
	input wire rst,
	input wire tck,
	input wire tms,
	input wire tms_driven,
	input wire tdi,
	input wire tdi_driven,
	input wire [`BSR_WIDTH-1:0] pin_sample,
	output reg tdo_reg,
	output reg tdo_oe_reg,
	output reg [`BSR_WIDTH-1:0] pin_drive_reg,
	output reg extest_reg,
	output reg [`IR_WIDTH-1:0] ir_reg
);

// ****************************************
// input synchronisers
// ****************************************
reg [1:0] tck_sync_reg;
reg [1:0] tms_sync_reg;
reg [1:0] tdi_sync_reg;
reg tck_prev_reg;
reg [`BSR_WIDTH-1:0] pin_s1_reg;
reg [`BSR_WIDTH-1:0] pin_s2_reg;
wire tms_eff;
wire tdi_eff;
wire tck_rise;
wire tck_fall;

// floating pins resolve high, as an internal pull-up would
assign tms_eff = tms | ~tms_driven;
assign tdi_eff = tdi | ~tdi_driven;

always @(posedge sys_clk)
begin
	if (rst)
	begin
		tck_sync_reg <= 2'h0;
		tms_sync_reg <= 2'h3;
		tdi_sync_reg <= 2'h3;
		tck_prev_reg <= 1'b0;
		pin_s1_reg <= {`BSR_WIDTH{1'b0}};
		pin_s2_reg <= {`BSR_WIDTH{1'b0}};
	end
	else
	begin
		tck_sync_reg <= {tck_sync_reg[0], tck};
		tms_sync_reg <= {tms_sync_reg[0], tms_eff};
		tdi_sync_reg <= {tdi_sync_reg[0], tdi_eff};
		tck_prev_reg <= tck_sync_reg[1];
		pin_s1_reg <= pin_sample;
		pin_s2_reg <= pin_s1_reg;
	end
end

// nothing moves unless the test clock toggles
assign tck_rise = tck_sync_reg[1] & ~tck_prev_reg;
assign tck_fall = ~tck_sync_reg[1] & tck_prev_reg;

// ****************************************
// controller
// ****************************************
wire [3:0] state;

// no test reset pin exists; rst models power-up only
tap_fsm fsm_inst
(
	.sys_clk(sys_clk),
	.rst(rst),
	.tck_rise(tck_rise),
	.tms(tms_sync_reg[1]),
	.state_reg(state)
);

// ****************************************
// instruction register
// ****************************************
reg [`IR_WIDTH-1:0] ir_shift_reg;

always @(posedge sys_clk)
begin
	if (rst)
	begin
		ir_shift_reg <= `IR_RESET_VAL;
		ir_reg <= `IR_RESET_VAL;
	end
	else if (state == `ST_RESET)
	begin
		// preset as soon as reset state is entered, not on a later tck rise
		ir_reg <= `IR_RESET_VAL;
	end
	else if (tck_rise)
	begin
		case (state)
			`ST_CAP_IR: ir_shift_reg <= {ir_shift_reg[`IR_WIDTH-1:2], `IR_CAPTURE_LSB};
			`ST_SHIFT_IR: ir_shift_reg <= {tdi_sync_reg[1], ir_shift_reg[`IR_WIDTH-1:1]};
			`ST_UPD_IR: ir_reg <= ir_shift_reg;
			default: ir_reg <= ir_reg;
		endcase
	end
end

// ****************************************
// data registers
// ****************************************
reg [`ID_WIDTH-1:0] id_reg;
reg bypass_reg;
reg [`BSR_WIDTH-1:0] bsr_reg;

function is_bsr;
	input [`IR_WIDTH-1:0] ir;
	begin
		is_bsr = (ir == `IR_EXTEST) || (ir == `IR_SAMPLE);
	end
endfunction

function is_id;
	input [`IR_WIDTH-1:0] ir;
	begin
		is_id = (ir == `IR_IDCODE);
	end
endfunction

always @(posedge sys_clk)
begin
	if (rst)
	begin
		id_reg <= `ID_CODE_VAL;
		bypass_reg <= 1'b0;
		bsr_reg <= {`BSR_WIDTH{1'b0}};
	end
	else if (tck_rise)
	begin
		if (state == `ST_CAP_DR)
		begin
			id_reg <= `ID_CODE_VAL;
			bypass_reg <= 1'b0;
			bsr_reg <= pin_s2_reg;
		end
		else if (state == `ST_SHIFT_DR)
		begin
			if (is_id(ir_reg))
				id_reg <= {tdi_sync_reg[1], id_reg[`ID_WIDTH-1:1]};
			else if (is_bsr(ir_reg))
				bsr_reg <= {tdi_sync_reg[1], bsr_reg[`BSR_WIDTH-1:1]};
			else
				bypass_reg <= tdi_sync_reg[1];
		end
	end
end

// ****************************************
// serial output, falling edge
// ****************************************
reg tdo_next;

always @*
begin
	tdo_next = bypass_reg;
	if (state == `ST_SHIFT_IR)
		tdo_next = ir_shift_reg[0];
	else if (is_id(ir_reg))
		tdo_next = id_reg[0];
	else if (is_bsr(ir_reg))
		tdo_next = bsr_reg[0];
end

always @(posedge sys_clk)
begin
	if (rst)
	begin
		tdo_reg <= 1'b0;
		tdo_oe_reg <= 1'b0;
		pin_drive_reg <= {`BSR_WIDTH{1'b0}};
		extest_reg <= 1'b0;
	end
	else if (tck_fall)
	begin
		tdo_reg <= tdo_next;
		tdo_oe_reg <= (state == `ST_SHIFT_IR) || (state == `ST_SHIFT_DR);
		extest_reg <= (ir_reg == `IR_EXTEST);
		if (state == `ST_UPD_DR || state == `ST_UPD_IR)
			pin_drive_reg <= bsr_reg;
	end
end

endmodule // sram_boundary_scan_tap

// file: src/tap_defs.vh
`ifndef TAP_DEFS_VH
`define TAP_DEFS_VH

// ****************************************
// controller states
// ****************************************
`define ST_RESET 4'h0
`define ST_IDLE 4'h1
`define ST_SEL_DR 4'h2
`define ST_CAP_DR 4'h3
`define ST_SHIFT_DR 4'h4
`define ST_EXIT1_DR 4'h5
`define ST_PAUSE_DR 4'h6
`define ST_EXIT2_DR 4'h7
`define ST_UPD_DR 4'h8
`define ST_SEL_IR 4'h9
`define ST_CAP_IR 4'ha
`define ST_SHIFT_IR 4'hb
`define ST_EXIT1_IR 4'hc
`define ST_PAUSE_IR 4'hd
`define ST_EXIT2_IR 4'he
`define ST_UPD_IR 4'hf

// ****************************************
// instructions and register layout
// ****************************************
`define IR_WIDTH 3
`define IR_EXTEST 3'h0
`define IR_IDCODE 3'h1
`define IR_SAMPLE 3'h2
`define IR_BYPASS 3'h7
`define IR_RESET_VAL 3'h1
`define IR_CAPTURE_LSB 2'h1
`define ID_WIDTH 32
// arbitrary neutral identification value
`define ID_CODE_VAL 32'h0000_0001
`define BSR_WIDTH 8

`endif

// file: src/tap_fsm.v
`timescale 1ns/10ps
`include "tap_defs.vh"

module tap_fsm
(
	input wire sys_clk,
	input wire rst,
	input wire tck_rise,
	input wire tms,
	output reg [3:0] state_reg
);

reg [3:0] state_next;

always @*
begin
	state_next = state_reg;
	case (state_reg)
		`ST_RESET: state_next = tms ? `ST_RESET : `ST_IDLE;
		`ST_IDLE: state_next = tms ? `ST_SEL_DR : `ST_IDLE;
		`ST_SEL_DR: state_next = tms ? `ST_SEL_IR : `ST_CAP_DR;
		`ST_CAP_DR: state_next = tms ? `ST_EXIT1_DR : `ST_SHIFT_DR;
		`ST_SHIFT_DR: state_next = tms ? `ST_EXIT1_DR : `ST_SHIFT_DR;
		`ST_EXIT1_DR: state_next = tms ? `ST_UPD_DR : `ST_PAUSE_DR;
		`ST_PAUSE_DR: state_next = tms ? `ST_EXIT2_DR : `ST_PAUSE_DR;
		`ST_EXIT2_DR: state_next = tms ? `ST_UPD_DR : `ST_SHIFT_DR;
		`ST_UPD_DR: state_next = tms ? `ST_SEL_DR : `ST_IDLE;
		`ST_SEL_IR: state_next = tms ? `ST_RESET : `ST_CAP_IR;
		`ST_CAP_IR: state_next = tms ? `ST_EXIT1_IR : `ST_SHIFT_IR;
		`ST_SHIFT_IR: state_next = tms ? `ST_EXIT1_IR : `ST_SHIFT_IR;
		`ST_EXIT1_IR: state_next = tms ? `ST_UPD_IR : `ST_PAUSE_IR;
		`ST_PAUSE_IR: state_next = tms ? `ST_EXIT2_IR : `ST_PAUSE_IR;
		`ST_EXIT2_IR: state_next = tms ? `ST_UPD_IR : `ST_SHIFT_IR;
		`ST_UPD_IR: state_next = tms ? `ST_SEL_DR : `ST_IDLE;
		default: state_next = `ST_RESET;
	endcase
end

// five high tms edges reach reset from any state by this graph
always @(posedge sys_clk)
begin
	if (rst)
		state_reg <= `ST_RESET;
	else if (tck_rise)
		state_reg <= state_next;
end

endmodule // tap_fsm

// file: tb/scan_ctl.sv
`timescale 1ns/10ps
// ***
// scan controller
// ***
module scan_ctl
(
	input wire logic sys_clk,
	input wire logic tdo_reg,
	output logic tck = 0,
	output logic tms = 1,
	output logic tdi = 1,
	output logic tms_driven = 1,
	output logic tdi_driven = 1
);
	// one 160 ns tck period; tck stands low between steps
	task automatic step(input logic m, d, f, output logic o);
		@(negedge sys_clk);
		tms_driven = !f;
		tdi_driven = !f;
		// a floating pin toggles so only the pull-up reading can pass
		tms = f ? ~tms : m;
		tdi = f ? ~tdi : d;
		repeat (4) @(negedge sys_clk);
		tck = 1;
		repeat (10) @(negedge sys_clk);
		tck = 0;
		repeat (5) @(negedge sys_clk);
		o = tdo_reg;
	endtask
endmodule // scan_ctl

// file: tb/tap_asserts.sv
`timescale 1ns/10ps
// ***
// tap port checks
// ***
module tap_chk
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic tck,
	input wire logic tdo_reg,
	input wire logic tdo_oe_reg,
	input wire logic extest_reg,
	input wire logic [2:0] ir_reg
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// outputs land 3-4 cycles after tck falls
	tdo_fall_a: assert property ($changed(tdo_reg) |-> !tck && $past(tck, 6))
		else $error("tdo off fall");
	oe_fall_a: assert property ($changed(tdo_oe_reg) |-> !tck && $past(tck, 6))
		else $error("oe off fall");
	extest_fall_a: assert property ($changed(extest_reg) |-> !tck && $past(tck, 6))
		else $error("extest off fall");
	quiet_idle_a: assert property ($stable(tck)[*8] |-> $stable({tdo_reg, tdo_oe_reg, ir_reg}))
		else $error("change without tck");
	reset_vals_a: assert property ($fell(rst) |-> ir_reg == 3'h1 && !tdo_oe_reg && !extest_reg)
		else $error("reset values");
	oe_hold_a: assert property ($rose(tdo_oe_reg) |=> tdo_oe_reg[*8])
		else $error("oe dropped");
	tdo_hold_a: assert property ($changed(tdo_reg) |=> $stable(tdo_reg)[*8])
		else $error("tdo unstable");
	ir_hold_a: assert property ($changed(ir_reg) |=> $stable(ir_reg)[*8])
		else $error("ir unstable");
	cover property ($rose(tdo_oe_reg));
	cover property ($rose(extest_reg));
	cover property ($changed(ir_reg));
endmodule // tap_chk

bind sram_boundary_scan_tap tap_chk chk(.sys_clk, .rst, .tck, .tdo_reg, .tdo_oe_reg, .extest_reg, .ir_reg);

// file: tb/tb_top.sv
`timescale 1ns/10ps
`include "tap_defs.vh"
module tb_top;
	logic sys_clk = 0, rst = 1, tck, tms, tms_driven, tdi, tdi_driven, tdo_reg, tdo_oe_reg, extest_reg;
	logic [7:0] pin_sample = 8'h00, pin_drive_reg;
	logic [2:0] ir_reg, op;
	logic [2:0] ops [5] = '{3'h0, 3'h2, 3'h1, 3'h3, 3'h7};
	logic [63:0] q, d;
	int errors = 0, comparisons = 0, cyc = 0;
	always #4 sys_clk = ~sys_clk;
	sram_boundary_scan_tap dut(.sys_clk, .rst, .tck, .tms, .tms_driven, .tdi, .tdi_driven,
		.pin_sample, .tdo_reg, .tdo_oe_reg, .pin_drive_reg, .extest_reg, .ir_reg);
	scan_ctl ctl(.sys_clk, .tdo_reg, .tck, .tms, .tdi, .tms_driven, .tdi_driven);
	task automatic chk(input logic [31:0] s, e, input string n);
		comparisons++;
		if (s !== e)
		begin
			errors++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic walk(input logic [63:0] m, input int n, input logic f);
		for (int i = 0; i < n; i++)
			ctl.step(m[i], d[i], f, q[i]);
	endtask
	function automatic logic [7:0] exp_dr(input logic [2:0] o);
		case (o)
			3'h0, 3'h2: return pin_sample;
			3'h1: return 8'(`ID_CODE_VAL);
			default: return {d[9:3], 1'b0};
		endcase
	endfunction
	task stop_test;
		$display("checks %0d mismatches %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			errors++;
			stop_test;
		end
	end
	// ***
	// main sequence
	// ***
	initial
	begin
		void'($urandom(32'hdee00471));
		repeat (16) @(negedge sys_clk);
		rst = 0;
		repeat (40) @(negedge sys_clk);
		chk(ir_reg, 3'h1, "ir");
		d = {$urandom, $urandom};
		walk(64'hc_0000_0002, 37, 0);
		chk(q[34:3], `ID_CODE_VAL, "id");
		chk(tdo_oe_reg, 1'b0, "oe");
		$display("id done");
		ops[3] = 3'h3 + 3'($urandom % 4);
		foreach (ops[i])
		begin
			op = ops[i];
			d = {$urandom, $urandom};
			d[6:4] = op;
			walk(64'hc3, 9, 0);
			chk(q[4:3], 2'h1, "ir capture");
			chk(ir_reg, op, "ir");
			chk(extest_reg, op == 3'h0, "extest");
			pin_sample = 8'($urandom);
			d = {$urandom, $urandom};
			walk(64'hc01, 13, 0);
			chk(q[9:2], exp_dr(op), "dr");
			if (op inside {3'h0, 3'h2})
				chk(pin_drive_reg, d[10:3], "drive");
			$display("op %h done", op);
		end
		walk(64'h2, 4, 0);
		chk(tdo_oe_reg, 1'b1, "oe shift");
		walk(64'h0, 5, 1);
		chk(ir_reg, 3'h1, "tms reset");
		chk(tdo_oe_reg, 1'b0, "oe");
		$display("reset done");
		stop_test;
	end
endmodule // tb_top
